// ===== otadt_cfg.svh
// register offsets, field positions, reset values and timing constants
`ifndef OTADT_CFG_SVH
`define OTADT_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OTADT_ADDR_CFG1 8'h01
`define OTADT_ADDR_CFG2 8'h02
`define OTADT_ADDR_EVENT_CFG 8'h04
`define OTADT_ADDR_CONV_RATE 8'h05
`define OTADT_ADDR_QUEUE_DEPTH 8'h06
`define OTADT_ADDR_MASK2 8'h09
`define OTADT_ADDR_DUTY_LIMIT 8'h19
`define OTADT_ADDR_HYSTERESIS 8'h1a
`define OTADT_ADDR_DUTY_MEASURED 8'h4e
`define OTADT_ADDR_STATUS2 8'h50

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define OTADT_CFG1_TIMER_BIT 2
`define OTADT_CFG1_COMP_BIT 3
`define OTADT_CFG2_BOOST_OFF_BIT 1
`define OTADT_EVCFG_REF_BIT 7
`define OTADT_EVCFG_WIN_LO 4
`define OTADT_EVCFG_WIN_HI 6
`define OTADT_DUTY_EXC_BIT 4
`define OTADT_PIN_STATE_BIT 2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define OTADT_CFG1_RST 8'h00
`define OTADT_CFG2_RST 8'h00
`define OTADT_EVENT_CFG_RST 8'h00
`define OTADT_CONV_RATE_RST 8'h07
`define OTADT_QUEUE_DEPTH_RST 8'h00
`define OTADT_MASK2_RST 8'h00
`define OTADT_DUTY_LIMIT_RST 8'hff
`define OTADT_HYSTERESIS_RST 8'h04

// ----------------------------------------------------------------------------
// rates and timing
// ----------------------------------------------------------------------------
`define OTADT_RATE_MAX 8'h0a
`define OTADT_RATE_NO_AVG 8'h08
`define OTADT_DUTY_NEVER 8'hff
`define OTADT_DUTY_SAMPLES 255
`define OTADT_SAMPLE_LAST 8'hfe
`define OTADT_WINDOW_MIN_US 250000
`define OTADT_CLK_FREQ_MHZ 125
`define OTADT_WIN_SEL_MAX 3'h5
`define OTADT_QUEUE_FULL 3'h4

`endif

// ===== otadt_pkg.sv
// types shared by the over-temperature alert and duty timer block
package otadt_pkg;

  // per-channel results from the measurement loop
  typedef struct packed {
    logic convDone;
    logic overLimit;
    logic overTherm;
    logic belowHys;
  } otadt_chan_t;

  // register access port strobes
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } otadt_reg_req_t;

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] eventCfg;
    logic [7:0] rateReg;
    logic [7:0] activeRate;
    logic [7:0] depthReg;
    logic [7:0] mask2;
    logic [7:0] dutyLimit;
    logic [7:0] hyst;
    logic [7:0] dutyMeasured;
    logic dutyExceeded;
    logic [2:0][2:0] queueCnt;
    logic [2:0] lastOut;
    logic [2:0] chanHot;
    logic [22:0] slotCnt;
    logic [7:0] sampleCnt;
    logic [7:0] lowCnt;
    logic [7:0] rdData;
  } otadt_state_t;

endpackage

// ===== otadt_overtemp_alert_and_duty_timer.sv
// over-temperature pin, fault queues, conversion rate and duty timer
//
// Overview of operation
// R1: fan-stall pin goes active whenever either fan has stalled, in stall role.
// R2: dual-use pin defaults to stall output; event config bit 7 makes it reference.
// R3: fault queue applies to temperature channels only, and only in latched mode.
// R4: one queue per channel; alert when count reaches programmed depth.
// R5: queue ignores alert status register bits.
// R6: depth from bits 3:0: 000x=1, 001x=2, 01xx=3, 1xxx=4.
// R7: queues empty on alert response, status 1 read, or reset.
// R8: clearing queues releases alert; refilled queue asserts it again.
// R9: rate code 0x00 is 0.0625/s doubling to 64/s at 0x0a; above reserved.
// R10: averaging only below 16 conversions per second.
// R11: new rate takes effect when current round-robin loop ends.
// R12: output mode drives pin low above limit, releases below limit minus hysteresis.
// R13: pin is an output after reset.
// R14: over-temperature boosts fans unless boost-inhibit bit is set.
// R15: timer bit makes pin an input; device stops driving and detects lows.
// R16: low time measured as fraction of window, stored in measured register.
// R17: window select 0.25 s doubling to 4 s, codes 5 to 7 give 8 s.
// R18: measured above limit sets status bit 4 and alerts unless masked.
// R19: limit 0x00 alerts on first assertion; 0xff never alerts.
// R20: limit scales linearly, 0xff is whole window.
// R21: limit checked when window elapses.
// R22: in input mode, per-channel event enables let device pull the pin low.
// R23: alert latched when config bit 3 is 0, comparator when 1.
// R24: mask blocks only alert; status bit still set.
// R25: in-limit reading restarts the channel's consecutive count; the code skips the restart once the queue is full.
`include "otadt_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module otadt_overtemp_alert_and_duty_timer #(
  parameter int SLOT_BASE_CYCLES = (`OTADT_WINDOW_MIN_US * `OTADT_CLK_FREQ_MHZ) / `OTADT_DUTY_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire otadt_pkg::otadt_reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic status1Read,
  input wire logic alertRespDone,
  input wire otadt_pkg::otadt_chan_t [2:0] chan,
  input wire logic loopDone,
  output logic [7:0] activeRate,
  output logic averageEn,
  output logic [7:0] thermHysteresis,
  input wire logic [1:0] fanStall,
  output logic fanFaultN,
  output logic fanFaultOe,
  output logic fanBoost,
  input wire logic overtempPinIn,
  output logic overtempPinOut,
  output logic overtempPinOe,
  output logic alertN
);

  otadt_pkg::otadt_state_t cur_ff;
  otadt_pkg::otadt_state_t nxt_cur;

  logic timerMode;
  logic compMode;
  logic queueClear;
  logic [2:0] queueDepth;
  logic [2:0] queueFull;
  logic pinLow;
  logic [2:0] winSel;
  logic [22:0] slotLen;
  logic slotEnd;
  logic [7:0] lowNow;
  logic tempAlert;
  logic dutyAlert;

  // ----------------------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------------------
  assign timerMode = cur_ff.cfg1[`OTADT_CFG1_TIMER_BIT];
  assign compMode = cur_ff.cfg1[`OTADT_CFG1_COMP_BIT];
  // fault queue state never looks at status bits, only at the readings and the clear strobes
  assign queueClear = alertRespDone | status1Read; // R7 R5

  always_comb begin
    if (cur_ff.depthReg[3]) begin
      queueDepth = 3'h4; // R6
    end else if (cur_ff.depthReg[2]) begin
      queueDepth = 3'h3; // R6
    end else if (cur_ff.depthReg[1]) begin
      queueDepth = 3'h2; // R6
    end else begin
      queueDepth = 3'h1; // R6
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      queueFull[i] = cur_ff.queueCnt[i] >= queueDepth; // R4
    end
  end

  // pin is only sampled for timing while it is an input
  assign pinLow = timerMode & ~overtempPinIn; // R15

  // window codes above four seconds saturate at eight seconds
  always_comb begin
    winSel = cur_ff.eventCfg[`OTADT_EVCFG_WIN_HI:`OTADT_EVCFG_WIN_LO];
    if (winSel > `OTADT_WIN_SEL_MAX) begin
      winSel = `OTADT_WIN_SEL_MAX; // R17
    end
  end

  // each window is split into 255 equal slots, one low sample per slot, so the
  // sample count is the percentage code directly and no divider is needed
  assign slotLen = 23'(SLOT_BASE_CYCLES) << winSel; // R17 R20
  assign slotEnd = cur_ff.slotCnt >= slotLen - 23'h1;
  assign lowNow = cur_ff.lowCnt + {7'h00, pinLow};

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;

    // register writes
    if (regReq.wrEn) begin
      if (regReq.addr == `OTADT_ADDR_CFG1) begin
        nxt_cur.cfg1 = regReq.wrData;
      end else if (regReq.addr == `OTADT_ADDR_CFG2) begin
        nxt_cur.cfg2 = regReq.wrData;
      end else if (regReq.addr == `OTADT_ADDR_EVENT_CFG) begin
        nxt_cur.eventCfg = regReq.wrData; // R2 R17 R22
      end else if (regReq.addr == `OTADT_ADDR_CONV_RATE) begin
        nxt_cur.rateReg = regReq.wrData;
      end else if (regReq.addr == `OTADT_ADDR_QUEUE_DEPTH) begin
        nxt_cur.depthReg = regReq.wrData;
      end else if (regReq.addr == `OTADT_ADDR_MASK2) begin
        nxt_cur.mask2 = regReq.wrData;
      end else if (regReq.addr == `OTADT_ADDR_DUTY_LIMIT) begin
        nxt_cur.dutyLimit = regReq.wrData;
      end else if (regReq.addr == `OTADT_ADDR_HYSTERESIS) begin
        nxt_cur.hyst = regReq.wrData;
      end
    end

    // register reads, data valid the cycle after the strobe
    nxt_cur.rdData = 8'h00;
    if (regReq.rdEn) begin
      if (regReq.addr == `OTADT_ADDR_CFG1) begin
        nxt_cur.rdData = cur_ff.cfg1;
      end else if (regReq.addr == `OTADT_ADDR_CFG2) begin
        nxt_cur.rdData = cur_ff.cfg2;
      end else if (regReq.addr == `OTADT_ADDR_EVENT_CFG) begin
        nxt_cur.rdData = cur_ff.eventCfg;
      end else if (regReq.addr == `OTADT_ADDR_CONV_RATE) begin
        nxt_cur.rdData = cur_ff.rateReg;
      end else if (regReq.addr == `OTADT_ADDR_QUEUE_DEPTH) begin
        nxt_cur.rdData = cur_ff.depthReg;
      end else if (regReq.addr == `OTADT_ADDR_MASK2) begin
        nxt_cur.rdData = cur_ff.mask2;
      end else if (regReq.addr == `OTADT_ADDR_DUTY_LIMIT) begin
        nxt_cur.rdData = cur_ff.dutyLimit;
      end else if (regReq.addr == `OTADT_ADDR_HYSTERESIS) begin
        nxt_cur.rdData = cur_ff.hyst;
      end else if (regReq.addr == `OTADT_ADDR_DUTY_MEASURED) begin
        nxt_cur.rdData = cur_ff.dutyMeasured; // R16
      end else if (regReq.addr == `OTADT_ADDR_STATUS2) begin
        nxt_cur.rdData[`OTADT_DUTY_EXC_BIT] = cur_ff.dutyExceeded;
        nxt_cur.rdData[`OTADT_PIN_STATE_BIT] = overtempPinOe | pinLow;
        nxt_cur.dutyExceeded = 1'b0;
      end
    end

    // rate change waits for the loop; a reserved code leaves the old rate running
    if (loopDone && cur_ff.rateReg <= `OTADT_RATE_MAX) begin
      nxt_cur.activeRate = cur_ff.rateReg; // R11 R9
    end

    // fault queues and per-channel hysteresis state
    for (int i = 0; i < 3; i++) begin
      // a clear in the same cycle as a reading empties first, then the reading counts
      if (queueClear) begin
        nxt_cur.queueCnt[i] = 3'h0; // R7 R8
      end
      if (chan[i].convDone) begin
        nxt_cur.lastOut[i] = chan[i].overLimit;
        // a full queue holds the latched alert until software empties it
        if (!chan[i].overLimit && !queueFull[i]) begin
          nxt_cur.queueCnt[i] = 3'h0; // R25
        end else if (chan[i].overLimit && nxt_cur.queueCnt[i] != `OTADT_QUEUE_FULL) begin
          nxt_cur.queueCnt[i] = nxt_cur.queueCnt[i] + 3'h1; // R4 R23
        end
      end
      if (chan[i].overTherm) begin
        nxt_cur.chanHot[i] = 1'b1; // R12
      end else if (chan[i].belowHys) begin
        nxt_cur.chanHot[i] = 1'b0; // R12
      end
    end

    // duty timer, only while the pin is an input
    if (!timerMode) begin
      nxt_cur.slotCnt = 23'h0;
      nxt_cur.sampleCnt = 8'h00;
      nxt_cur.lowCnt = 8'h00;
    end else if (slotEnd) begin
      nxt_cur.slotCnt = 23'h0;
      if (cur_ff.sampleCnt == `OTADT_SAMPLE_LAST) begin
        nxt_cur.sampleCnt = 8'h00;
        nxt_cur.lowCnt = 8'h00;
        nxt_cur.dutyMeasured = lowNow; // R16
        if (lowNow > cur_ff.dutyLimit && cur_ff.dutyLimit != `OTADT_DUTY_NEVER) begin
          nxt_cur.dutyExceeded = 1'b1; // R21 R18 R19
        end
      end else begin
        nxt_cur.sampleCnt = cur_ff.sampleCnt + 8'h01;
        nxt_cur.lowCnt = lowNow;
      end
    end else begin
      nxt_cur.slotCnt = cur_ff.slotCnt + 23'h1;
    end

    // a zero limit trips on the first low, without waiting for the window
    if (pinLow && cur_ff.dutyLimit == 8'h00) begin
      nxt_cur.dutyExceeded = 1'b1; // R19
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
      cur_ff.cfg1 <= `OTADT_CFG1_RST; // R13
      cur_ff.cfg2 <= `OTADT_CFG2_RST;
      cur_ff.eventCfg <= `OTADT_EVENT_CFG_RST; // R2
      cur_ff.rateReg <= `OTADT_CONV_RATE_RST;
      cur_ff.activeRate <= `OTADT_CONV_RATE_RST;
      cur_ff.depthReg <= `OTADT_QUEUE_DEPTH_RST;
      cur_ff.mask2 <= `OTADT_MASK2_RST;
      cur_ff.dutyLimit <= `OTADT_DUTY_LIMIT_RST;
      cur_ff.hyst <= `OTADT_HYSTERESIS_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign regRdData = cur_ff.rdData;
  assign activeRate = cur_ff.activeRate;
  assign averageEn = cur_ff.activeRate < `OTADT_RATE_NO_AVG; // R10
  assign thermHysteresis = cur_ff.hyst; // R12

  // in reference role the pin is analog, so digital drive must stay off
  assign fanFaultOe = ~cur_ff.eventCfg[`OTADT_EVCFG_REF_BIT]; // R2
  assign fanFaultN = ~(|fanStall); // R1

  assign fanBoost = (|cur_ff.chanHot) & ~cur_ff.cfg2[`OTADT_CFG2_BOOST_OFF_BIT]; // R14

  // open drain: only ever pulls low
  assign overtempPinOut = 1'b0;
  always_comb begin
    if (timerMode) begin
      overtempPinOe = |(cur_ff.chanHot & cur_ff.eventCfg[2:0]); // R22 R15
    end else begin
      overtempPinOe = |cur_ff.chanHot; // R12 R13
    end
  end

  // comparator mode bypasses the queues and follows the latest readings
  assign tempAlert = compMode ? (|cur_ff.lastOut) : (|queueFull); // R3 R23 R8
  assign dutyAlert = cur_ff.dutyExceeded & ~cur_ff.mask2[`OTADT_DUTY_EXC_BIT]; // R24 R18
  assign alertN = ~(tempAlert | dutyAlert);

endmodule

`default_nettype wire

// ===== otadt_properties.sv
// port checks for the over-temperature alert and duty timer
`timescale 1ns/10ps
`default_nettype none
`include "otadt_cfg.svh"
module otadt_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire otadt_pkg::otadt_reg_req_t regReq,
  input wire otadt_pkg::otadt_chan_t [2:0] chan,
  input wire logic loopDone,
  input wire logic [7:0] activeRate,
  input wire logic averageEn,
  input wire logic [1:0] fanStall,
  input wire logic fanFaultN,
  input wire logic fanFaultOe,
  input wire logic fanBoost,
  input wire logic overtempPinOe
);
  // ----
  // shadow of cfg1, cfg2, event cfg taken from the write strobes
  // ----
  logic [23:0] shadow_ff;
  logic [23:0] nxt_shadow;
  logic [2:0] hot;
  logic [2:0] cool;
  always_comb begin
    nxt_shadow = shadow_ff;
    if (regReq.wrEn && regReq.addr == `OTADT_ADDR_CFG1) nxt_shadow[7:0] = regReq.wrData;
    if (regReq.wrEn && regReq.addr == `OTADT_ADDR_CFG2) nxt_shadow[15:8] = regReq.wrData;
    if (regReq.wrEn && regReq.addr == `OTADT_ADDR_EVENT_CFG) nxt_shadow[23:16] = regReq.wrData;
    hot = {chan[2].overTherm, chan[1].overTherm, chan[0].overTherm};
    cool = {chan[2].belowHys, chan[1].belowHys, chan[0].belowHys};
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadow_ff <= {`OTADT_EVENT_CFG_RST, `OTADT_CFG2_RST, `OTADT_CFG1_RST};
    end else begin
      shadow_ff <= nxt_shadow;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----
  // assertions
  // ----
  a_stall_follows: assert property (fanFaultOe |-> fanFaultN == ~|fanStall)
    else $error("stall output does not follow the fans");
  a_stall_role: assert property (fanFaultOe == !shadow_ff[23])
    else $error("stall pin role wrong");
  a_hot_sets_pin: assert property (!shadow_ff[2] && !regReq.wrEn && |hot |=> overtempPinOe)
    else $error("pin not pulled on over-temperature");
  a_hys_clears_pin: assert property (!shadow_ff[2] && !regReq.wrEn && &cool && !(|hot) |=> !overtempPinOe)
    else $error("pin not released below hysteresis");
  a_input_released: assert property (shadow_ff[2] && shadow_ff[18:16] == 3'h0 && !regReq.wrEn |=> !overtempPinOe)
    else $error("pin driven in input mode");
  a_boost_inhibit: assert property (shadow_ff[9] && !regReq.wrEn |=> !fanBoost)
    else $error("boost while inhibited");
  a_rate_on_loop: assert property ($changed(activeRate) |-> $past(loopDone))
    else $error("rate changed outside loop end");
  a_rate_legal: assert property (activeRate <= `OTADT_RATE_MAX)
    else $error("reserved rate applied");
  a_avg_slow: assert property (averageEn == (activeRate < `OTADT_RATE_NO_AVG))
    else $error("averaging wrong for rate");
  c_boost: cover property (fanBoost);
  c_input_pull: cover property (shadow_ff[2] && overtempPinOe);
  c_rate_move: cover property ($changed(activeRate));
endmodule
`default_nettype wire

// ===== otadt_hot_source.sv
// processor hot-signal source sharing the open-drain over-temperature pin
`timescale 1ns/10ps
`default_nettype none
module otadt_hot_source (
  input wire logic hotReq,
  input wire logic devOe,
  input wire logic devOut,
  output logic pinLevel
);
  // pull-up holds the line high only while nobody pulls it down
  assign pinLevel = ~(hotReq | (devOe & ~devOut));
endmodule
`default_nettype wire

// ===== otadt_overtemp_alert_and_duty_timer_test.sv
// self-checking bench for the over-temperature alert and duty timer
`timescale 1ns/10ps
`default_nettype none
`include "otadt_cfg.svh"
module otadt_overtemp_alert_and_duty_timer_test;
  // ----
  // signals and instances
  // ----
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  otadt_pkg::otadt_reg_req_t regReq = '0;
  // idle channels sit below the hysteresis point
  otadt_pkg::otadt_chan_t [2:0] chan = {3{4'h1}};
  logic [2:0] pulses = 3'h0;
  logic hotReq = 1'h0;
  logic [1:0] fanStall = 2'h0;
  logic [7:0] regRdData, activeRate, thermHysteresis;
  logic averageEn, fanFaultN, fanFaultOe, fanBoost, overtempPinIn, overtempPinOut, overtempPinOe, alertN;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] regA [6] = '{8'h04, 8'h06, 8'h19, 8'h1a, 8'h05, 8'h7f};
  logic [7:0] regE [6] = '{`OTADT_EVENT_CFG_RST, `OTADT_QUEUE_DEPTH_RST, `OTADT_DUTY_LIMIT_RST,
    `OTADT_HYSTERESIS_RST, `OTADT_CONV_RATE_RST, 8'h00};
  logic [7:0] depth [4] = '{8'h01, 8'h03, 8'h05, 8'h0e};
  logic [7:0] rate [4] = '{8'h0a, 8'h0b, 8'h08, 8'h07};
  logic [7:0] rateExp [4] = '{8'h0a, 8'h0a, 8'h08, 8'h07};
  always #4 clk_sys = ~clk_sys;
  otadt_overtemp_alert_and_duty_timer #(.SLOT_BASE_CYCLES(4)) otadt_overtemp_alert_and_duty_timer_inst (
    .clk_sys(clk_sys), .resetn(resetn), .regReq(regReq), .regRdData(regRdData), .status1Read(pulses[2]),
    .alertRespDone(pulses[1]), .chan(chan), .loopDone(pulses[0]), .activeRate(activeRate),
    .averageEn(averageEn), .thermHysteresis(thermHysteresis), .fanStall(fanStall), .fanFaultN(fanFaultN),
    .fanFaultOe(fanFaultOe), .fanBoost(fanBoost), .overtempPinIn(overtempPinIn),
    .overtempPinOut(overtempPinOut), .overtempPinOe(overtempPinOe), .alertN(alertN));
  otadt_hot_source otadt_hot_source_inst (.hotReq(hotReq), .devOe(overtempPinOe), .devOut(overtempPinOut),
    .pinLevel(overtempPinIn));
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // extra cycle after a write so registered outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    regReq = '{1'h1, 1'h0, a, d};
    @(posedge clk_sys) #1;
    regReq.wrEn = 1'h0;
    @(posedge clk_sys) #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys) #1;
    regReq = '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk_sys) #1;
    regReq.rdEn = 1'h0;
    chk(regRdData & m, e);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clk_sys) #1;
    pulses = v;
    @(posedge clk_sys) #1;
    pulses = 3'h0;
  endtask
  task automatic rdg(input int c, input logic ov);
    @(posedge clk_sys) #1;
    chan[c].convDone = 1'h1;
    chan[c].overLimit = ov;
    @(posedge clk_sys) #1;
    chan[c].convDone = 1'h0;
  endtask
  task automatic temp(input int c, input logic ot, input logic bh);
    @(posedge clk_sys) #1;
    chan[c].overTherm = ot;
    chan[c].belowHys = bh;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      summarize();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 resetn = 1'h1;
    chk(8'(fanFaultOe), 8'h01);
    fanStall = 2'h2;
    #1 chk(8'(fanFaultN), 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdc(regA[i], 8'hff, regE[i]);
      wr(regA[i], 8'h5a);
      rdc(regA[i], 8'hff, (i == 5) ? 8'h00 : 8'h5a);
    end
    chk(thermHysteresis, 8'h5a);
    wr(8'h04, 8'h80);
    chk(8'(fanFaultOe), 8'h00);
    wr(8'h04, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, depth[i]);
      for (int n = 0; n < i; n++) rdg(i % 3, 1'h1);
      rdg(i % 3, 1'h0);
      for (int n = 0; n < i; n++) rdg(i % 3, 1'h1);
      chk(8'(alertN), 8'h01);
      rdg(i % 3, 1'h1);
      chk(8'(alertN), 8'h00);
      rdg(i % 3, 1'h0);
      chk(8'(alertN), 8'h00);
      pulse({i[0], ~i[0], 1'h0});
      chk(8'(alertN), 8'h01);
    end
    for (int n = 0; n < 4; n++) rdg(0, 1'h1);
    chk(8'(alertN), 8'h00);
    pulse(3'h4);
    wr(8'h01, 8'h08);
    for (int c = 0; c < 3; c++) rdg(c, 1'h0);
    rdg(1, 1'h1);
    chk(8'(alertN), 8'h00);
    rdg(1, 1'h0);
    chk(8'(alertN), 8'h01);
    wr(8'h01, 8'h00);
    pulse(3'h4);
    $display("test fault queue done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h05, rate[i]);
      chk(activeRate, rateExp[(i + 3) % 4]);
      pulse(3'h1);
      chk(activeRate, rateExp[i]);
      chk(8'(averageEn), 8'(rateExp[i] < 8'h08));
    end
    $display("test rate done");
    temp(1, 1'h1, 1'h0);
    chk(8'(overtempPinIn), 8'h00);
    chk(8'(fanBoost), 8'h01);
    wr(8'h02, 8'h02);
    chk(8'(fanBoost), 8'h00);
    wr(8'h02, 8'h00);
    temp(1, 1'h0, 1'h0);
    chk(8'(overtempPinOe), 8'h01);
    temp(1, 1'h0, 1'h1);
    chk(8'(overtempPinOe), 8'h00);
    temp(1, 1'h1, 1'h0);
    wr(8'h01, 8'h04);
    chk(8'(overtempPinIn), 8'h01);
    wr(8'h04, 8'h01);
    chk(8'(overtempPinOe), 8'h00);
    wr(8'h04, 8'h02);
    chk(8'(overtempPinOe), 8'h01);
    temp(1, 1'h0, 1'h1);
    wr(8'h04, 8'h00);
    $display("test pin done");
    wr(8'h19, 8'h00);
    hotReq = 1'h1;
    wr(8'h19, 8'hff);
    rdc(8'h50, 8'h10, 8'h10);
    repeat (2100) @(posedge clk_sys);
    rdc(8'h4e, 8'hff, 8'hff);
    wr(8'h4e, 8'h00);
    rdc(8'h4e, 8'hff, 8'hff);
    rdc(8'h50, 8'h10, 8'h00);
    wr(8'h19, 8'h20);
    repeat (1100) @(posedge clk_sys);
    chk(8'(alertN), 8'h00);
    wr(8'h09, 8'h10);
    chk(8'(alertN), 8'h01);
    rdc(8'h50, 8'h10, 8'h10);
    $display("test duty timer done");
    summarize();
  end
endmodule
bind otadt_overtemp_alert_and_duty_timer otadt_properties otadt_properties_inst (.clk_sys(clk_sys),
  .resetn(resetn), .regReq(regReq), .chan(chan), .loopDone(loopDone), .activeRate(activeRate),
  .averageEn(averageEn), .fanStall(fanStall), .fanFaultN(fanFaultN), .fanFaultOe(fanFaultOe),
  .fanBoost(fanBoost), .overtempPinOe(overtempPinOe));
`default_nettype wire
